// *** common/usb_hs_pkg.sv ***
package usb_hs_pkg;

  // Register indices as printed, byte address is four times the index
  localparam logic [7:0] IDX_EVENT_FLAGS_ONE = 8'h3a;
  localparam logic [7:0] IDX_EP0_CONTROL     = 8'h3b;
  localparam logic [7:0] IDX_EP12_CONTROL    = 8'h3c;
  localparam logic [7:0] IDX_EP12_EN_STALL   = 8'h37;
  localparam int         ADDR_W              = 12;

  // Event flags one bit positions
  localparam int B_TXD_FLAG     = 7;
  localparam int B_EOP_FLAG     = 6;
  localparam int B_WAKE_FLAG    = 5;
  localparam int B_WAKE_CLEAR   = 4;
  localparam int B_TXD_IE       = 3;
  localparam int B_EOP_IE       = 2;
  localparam int B_TXD_CLEAR    = 1;
  localparam int B_EOP_CLEAR    = 0;
  // Endpoint 0 / endpoint 1-2 control bit positions
  localparam int B_SEQ          = 7;
  localparam int B_CTRL_FORCE_STALL       = 6;
  localparam int B_SELECT       = 6;
  localparam int B_TXE          = 5;
  localparam int B_RXE          = 4;
  localparam int B_FORCE_WAKE   = 4;
  // Endpoint 1-2 enable/stall bit positions
  localparam int B_FIRST_CLEAR  = 6;
  localparam int B_FIRST_FLAG   = 5;
  localparam int B_EN2          = 3;
  localparam int B_EN1          = 2;
  localparam int B_SECOND_EP_FORCE_STALL       = 1;
  localparam int B_FIRST_EP_FORCE_STALL       = 0;

  localparam logic [7:0] RESET_BYTE = 8'h00;
  localparam logic [1:0] AXI_OKAY   = 2'b00;
  localparam logic [1:0] AXI_SLVERR = 2'b10;

  typedef enum logic [1:0] {
    HS_ACK   = 2'b00,
    HS_NAK   = 2'b01,
    HS_STALL = 2'b10,
    HS_NONE  = 2'b11
  } handshake_e;

  typedef enum logic [1:0] {
    TOK_IN    = 2'b00,
    TOK_OUT   = 2'b01,
    TOK_SETUP = 2'b10
  } token_e;

  // Token seen by the serial engine, one-cycle strobe
  typedef struct packed {
    logic       valid;
    token_e     kind;
    logic [3:0] endpoint;
  } token_s;

  // Answer decision for the serial engine
  typedef struct packed {
    logic       valid;
    handshake_e handshake;
    logic       data_one;
    logic [3:0] byte_count;
    logic       use_shared;
  } answer_s;

endpackage

// *** src/usb_endpoint_handshake_control.sv ***
// Chosen here: the AXI4-Lite register port.
`timescale 1ns/100ps
// Notes on behaviour
// - Shared transmit flag sets only after shared buffer sent and host ACKed.
// - Shared transmit flag clears only on write of 1 to its clear bit.
// - Endpoint 1/2 IN gets NAK while shared enable low or flag set.
// - End-of-packet flag sets on valid end of packet; clear by writing 1.
// - Interrupt request when end-of-packet flag sets with its enable on.
// - Interrupt request when shared transmit flag sets with its enable on.
// - Wakeup flag sets on bus activity during suspend; cleared by writing 1.
// - Endpoint 0 toggle bit picks DATA1/DATA0; hardware never toggles it.
// - Endpoint 1/2 toggle bit picks DATA1/DATA0; only software changes it.
// - Endpoint 0 stall forces STALL on IN/OUT; SETUP clears stall bit.
// - Endpoint 0 IN gets NAK while transmit enable low or flag set.
// - Endpoint 0 OUT gets NAK while receive enable low or flag set.
// - Four-bit endpoint 0 transmit byte count in bits 3 to 0.
// - Four-bit endpoint 1/2 transmit byte count, reset to zero.
// - Select bit gives buffer to endpoint 2 or 1; mismatch gets NAK.
// - Force-wakeup bit drives K state; does not set wakeup flag.
// - In-before-out flag sets when ep0 tx flag set as rx flag sets.
// - Endpoints 1 and 2 answer IN only while their enable or stall bit is set.
// - Endpoint 1/2 stall bit forces STALL on IN or OUT tokens.
// - Suspend bit blocks all answers and arms wakeup detection.
// - Module disabled ignores all tokens.
module usb_endpoint_handshake_control (
  input  wire logic                      CLK_IN,
  input  wire logic                      SRST_IN,
  input  wire logic [usb_hs_pkg::ADDR_W-1:0] S_AXI_AWADDR_IN,
  input  wire logic                      S_AXI_AWVALID_IN,
  output logic                           S_AXI_AWREADY_OUT,
  input  wire logic [31:0]               S_AXI_WDATA_IN,
  input  wire logic [3:0]                S_AXI_WSTRB_IN,
  input  wire logic                      S_AXI_WVALID_IN,
  output logic                           S_AXI_WREADY_OUT,
  output logic [1:0]                     S_AXI_BRESP_OUT,
  output logic                           S_AXI_BVALID_OUT,
  input  wire logic                      S_AXI_BREADY_IN,
  input  wire logic [usb_hs_pkg::ADDR_W-1:0] S_AXI_ARADDR_IN,
  input  wire logic                      S_AXI_ARVALID_IN,
  output logic                           S_AXI_ARREADY_OUT,
  output logic [31:0]                    S_AXI_RDATA_OUT,
  output logic [1:0]                     S_AXI_RRESP_OUT,
  output logic                           S_AXI_RVALID_OUT,
  input  wire logic                      S_AXI_RREADY_IN,
  input  wire usb_hs_pkg::token_s        TOKEN_IN,
  input  wire logic                      SHARED_TX_ACKED_IN,
  input  wire logic                      CTRL_RX_SETTING_IN,
  input  wire logic                      CTRL_TX_DONE_FLAG_IN,
  input  wire logic                      CTRL_RX_DONE_FLAG_IN,
  input  wire logic                      SUSPEND_BIT_IN,
  input  wire logic                      MODULE_ENABLE_IN,
  input  wire logic                      LINE_DP_IN,
  input  wire logic                      LINE_DM_IN,
  output usb_hs_pkg::answer_s            ANSWER_OUT,
  output logic                           DRIVE_K_OUT,
  output logic                           USB_IRQ_OUT
);
  import usb_hs_pkg::*;

  localparam logic [1:0] LINE_IDLE_J = 2'b01;
  // Cycles for our own K drive to come back through pins and synchroniser
  localparam int         K_ECHO_CYCLES = 3;
  localparam logic [1:0] LINE_SE0    = 2'b00;

  // Control fields
  logic       ctrl_tx_toggle;
  logic       ctrl_force_stall;
  logic       ctrl_tx_enable;
  logic       ctrl_rx_enable;
  logic [3:0] ctrl_tx_byte_count;
  logic       shared_tx_toggle;
  logic       shared_buffer_select;
  logic       shared_tx_enable;
  logic       force_wakeup_drive;
  logic [3:0] shared_tx_byte_count;
  logic       second_ep_enable;
  logic       first_ep_enable;
  logic       second_ep_force_stall;
  logic       first_ep_force_stall;
  logic       shared_tx_irq_enable;
  logic       end_packet_irq_enable;
  // Flags
  logic       shared_tx_done_flag;
  logic       end_packet_flag;
  logic       wakeup_seen_flag;
  logic       in_before_out_flag;

  // Line synchronisers, first stage read only by second
  logic [1:0] line_meta;
  logic [1:0] line_sync;
  logic [1:0] line_prev;
  logic       eop_armed;

  // AXI write side
  logic                 aw_held;
  logic                 w_held;
  logic [ADDR_W-1:0]    aw_addr;
  logic [31:0]          w_data;
  logic [3:0]           w_strb;
  logic                 wr_fire;
  logic [7:0]           wr_idx;
  logic                 wr_hit;
  logic [7:0]           wb;

  function automatic logic idx_mapped(input logic [7:0] idx);
    return idx == IDX_EVENT_FLAGS_ONE || idx == IDX_EP0_CONTROL ||
           idx == IDX_EP12_CONTROL || idx == IDX_EP12_EN_STALL;
  endfunction

  function automatic logic [7:0] word_index(input logic [ADDR_W-1:0] a);
    return a[9:2];
  endfunction

  assign wr_fire = aw_held && w_held && !S_AXI_BVALID_OUT;
  assign wr_idx  = word_index(aw_addr);
  assign wr_hit  = wr_fire && w_strb[0] && (aw_addr[ADDR_W-1:10] == '0) &&
                   idx_mapped(wr_idx);
  assign wb      = w_data[7:0];

  function automatic logic wr_to(input logic hit, input logic [7:0] idx,
                                 input logic [7:0] target);
    return hit && idx == target;
  endfunction

  logic w_flags;
  logic w_ep0;
  logic w_ep12;
  logic w_enst;
  assign w_flags = wr_to(wr_hit, wr_idx, IDX_EVENT_FLAGS_ONE);
  assign w_ep0   = wr_to(wr_hit, wr_idx, IDX_EP0_CONTROL);
  assign w_ep12  = wr_to(wr_hit, wr_idx, IDX_EP12_CONTROL);
  assign w_enst  = wr_to(wr_hit, wr_idx, IDX_EP12_EN_STALL);

  always_ff @(posedge CLK_IN) begin
    if (SRST_IN) begin
      aw_held           <= 1'b0;
      aw_addr           <= '0;
      S_AXI_AWREADY_OUT <= 1'b0;
    end else begin
      S_AXI_AWREADY_OUT <= !aw_held && !S_AXI_AWREADY_OUT;
      if (S_AXI_AWVALID_IN && S_AXI_AWREADY_OUT) begin
        aw_held <= 1'b1;
        aw_addr <= S_AXI_AWADDR_IN;
        S_AXI_AWREADY_OUT <= 1'b0;
      end else if (wr_fire) begin
        aw_held <= 1'b0;
      end
    end
  end

  always_ff @(posedge CLK_IN) begin
    if (SRST_IN) begin
      w_held           <= 1'b0;
      w_data           <= '0;
      w_strb           <= '0;
      S_AXI_WREADY_OUT <= 1'b0;
    end else begin
      S_AXI_WREADY_OUT <= !w_held && !S_AXI_WREADY_OUT;
      if (S_AXI_WVALID_IN && S_AXI_WREADY_OUT) begin
        w_held <= 1'b1;
        w_data <= S_AXI_WDATA_IN;
        w_strb <= S_AXI_WSTRB_IN;
        S_AXI_WREADY_OUT <= 1'b0;
      end else if (wr_fire) begin
        w_held <= 1'b0;
      end
    end
  end

  always_ff @(posedge CLK_IN) begin
    if (SRST_IN) begin
      S_AXI_BVALID_OUT <= 1'b0;
      S_AXI_BRESP_OUT  <= AXI_OKAY;
    end else if (wr_fire) begin
      S_AXI_BVALID_OUT <= 1'b1;
      S_AXI_BRESP_OUT  <= ((aw_addr[ADDR_W-1:10] == '0) && idx_mapped(wr_idx)) ?
                          AXI_OKAY : AXI_SLVERR;
    end else if (S_AXI_BREADY_IN) begin
      S_AXI_BVALID_OUT <= 1'b0;
    end
  end

  // Control registers, written through byte lane 0 only
  always_ff @(posedge CLK_IN) begin
    if (SRST_IN) begin
      {ctrl_tx_toggle, ctrl_tx_enable, ctrl_rx_enable} <= 3'b000;
      ctrl_tx_byte_count <= RESET_BYTE[3:0];
    end else if (w_ep0) begin
      ctrl_tx_toggle     <= wb[B_SEQ];
      ctrl_tx_enable     <= wb[B_TXE];
      ctrl_rx_enable     <= wb[B_RXE];
      ctrl_tx_byte_count <= wb[3:0];
    end
  end

  // SETUP clears stall, taking precedence over a write
  always_ff @(posedge CLK_IN) begin
    if (SRST_IN) begin
      ctrl_force_stall <= 1'b0;
    end else if (TOKEN_IN.valid && MODULE_ENABLE_IN && TOKEN_IN.kind == TOK_SETUP &&
                 TOKEN_IN.endpoint == 4'h0) begin
      ctrl_force_stall <= 1'b0;
    end else if (w_ep0) begin
      ctrl_force_stall <= wb[B_CTRL_FORCE_STALL];
    end
  end

  always_ff @(posedge CLK_IN) begin
    if (SRST_IN) begin
      {shared_tx_toggle, shared_buffer_select, shared_tx_enable} <= 3'b000;
      force_wakeup_drive   <= 1'b0;
      shared_tx_byte_count <= RESET_BYTE[3:0];
    end else if (w_ep12) begin
      shared_tx_toggle     <= wb[B_SEQ];
      shared_buffer_select <= wb[B_SELECT];
      shared_tx_enable     <= wb[B_TXE];
      force_wakeup_drive   <= wb[B_FORCE_WAKE];
      shared_tx_byte_count <= wb[3:0];
    end
  end

  always_ff @(posedge CLK_IN) begin
    if (SRST_IN) begin
      {second_ep_enable, first_ep_enable} <= 2'b00;
      {second_ep_force_stall, first_ep_force_stall} <= 2'b00;
    end else if (w_enst) begin
      second_ep_enable      <= wb[B_EN2];
      first_ep_enable       <= wb[B_EN1];
      second_ep_force_stall <= wb[B_SECOND_EP_FORCE_STALL];
      first_ep_force_stall  <= wb[B_FIRST_EP_FORCE_STALL];
    end
  end

  always_ff @(posedge CLK_IN) begin
    if (SRST_IN) begin
      shared_tx_irq_enable  <= 1'b0;
      end_packet_irq_enable <= 1'b0;
    end else if (w_flags) begin
      shared_tx_irq_enable  <= wb[B_TXD_IE];
      end_packet_irq_enable <= wb[B_EOP_IE];
    end
  end

  // Line sampling; idle J is D- high, D+ low at low speed
  always_ff @(posedge CLK_IN) begin
    if (SRST_IN) begin
      line_meta <= LINE_IDLE_J;
      line_sync <= LINE_IDLE_J;
      line_prev <= LINE_IDLE_J;
      eop_armed <= 1'b0;
    end else begin
      line_meta <= {LINE_DP_IN, LINE_DM_IN};
      line_sync <= line_meta;
      line_prev <= line_sync;
      if (line_sync == LINE_SE0) begin
        eop_armed <= 1'b1;
      end else if (line_sync == LINE_IDLE_J || line_sync != line_prev) begin
        eop_armed <= 1'b0;
      end
    end
  end

  logic eop_seen;
  logic activity_seen;
  logic [K_ECHO_CYCLES-1:0] k_echo;
  logic own_k_echo;
  // Released K still shows on the synchronised lines for a few cycles
  assign own_k_echo = force_wakeup_drive || DRIVE_K_OUT || (|k_echo);
  // Valid end of packet: SE0 followed by idle J
  assign eop_seen      = eop_armed && line_sync == LINE_IDLE_J;
  assign activity_seen = line_sync != LINE_IDLE_J;

  // Flags: set wins over clear in the same cycle
  always_ff @(posedge CLK_IN) begin
    if (SRST_IN) begin
      shared_tx_done_flag <= 1'b0;
    // set on ACK of shared buffer
    end else if (SHARED_TX_ACKED_IN) begin
      shared_tx_done_flag <= 1'b1;
    end else if (w_flags && wb[B_TXD_CLEAR]) begin
      shared_tx_done_flag <= 1'b0;
    end
  end

  always_ff @(posedge CLK_IN) begin
    if (SRST_IN) begin
      end_packet_flag <= 1'b0;
    end else if (eop_seen) begin
      end_packet_flag <= 1'b1;
    end else if (w_flags && wb[B_EOP_CLEAR]) begin
      end_packet_flag <= 1'b0;
    end
  end

  always_ff @(posedge CLK_IN) begin
    if (SRST_IN) begin
      wakeup_seen_flag <= 1'b0;
    // activity in suspend, not our own K drive
    end else if (SUSPEND_BIT_IN && activity_seen && !own_k_echo) begin
      wakeup_seen_flag <= 1'b1;
    end else if (w_flags && wb[B_WAKE_CLEAR]) begin
      wakeup_seen_flag <= 1'b0;
    end
  end

  always_ff @(posedge CLK_IN) begin
    if (SRST_IN) begin
      in_before_out_flag <= 1'b0;
    // tx flag still set as rx flag sets
    end else if (CTRL_RX_SETTING_IN && CTRL_TX_DONE_FLAG_IN) begin
      in_before_out_flag <= 1'b1;
    end else if (w_enst && wb[B_FIRST_CLEAR]) begin
      in_before_out_flag <= 1'b0;
    end
  end

  // interrupt on flag rising with enable
  logic shared_prev;
  logic eop_prev;
  always_ff @(posedge CLK_IN) begin
    if (SRST_IN) begin
      shared_prev <= 1'b0;
      eop_prev    <= 1'b0;
      USB_IRQ_OUT <= 1'b0;
    end else begin
      shared_prev <= shared_tx_done_flag;
      eop_prev    <= end_packet_flag;
      USB_IRQ_OUT <= (shared_tx_done_flag && !shared_prev && shared_tx_irq_enable) ||
                     (end_packet_flag && !eop_prev && end_packet_irq_enable);
    end
  end

  // K drive follows the bit; software times it
  always_ff @(posedge CLK_IN) begin
    if (SRST_IN) begin
      DRIVE_K_OUT <= 1'b0;
      k_echo      <= '0;
    end else begin
      DRIVE_K_OUT <= force_wakeup_drive;
      k_echo      <= {k_echo[K_ECHO_CYCLES-2:0], DRIVE_K_OUT};
    end
  end

  // Handshake decision
  always_ff @(posedge CLK_IN) begin
    if (SRST_IN) begin
      ANSWER_OUT <= '{valid: 1'b0, handshake: HS_NONE, data_one: 1'b0,
                      byte_count: 4'h0, use_shared: 1'b0};
    end else begin
      ANSWER_OUT <= '{valid: 1'b0, handshake: HS_NONE, data_one: 1'b0,
                      byte_count: 4'h0, use_shared: 1'b0};
      if (TOKEN_IN.valid && MODULE_ENABLE_IN && !SUSPEND_BIT_IN) begin
        ANSWER_OUT.valid <= 1'b1;
        case (TOKEN_IN.endpoint)
          4'h0: begin
            if (TOKEN_IN.kind == TOK_SETUP) begin
              ANSWER_OUT.handshake <= HS_ACK;
            end else if (ctrl_force_stall) begin
              ANSWER_OUT.handshake <= HS_STALL;
            end else if (TOKEN_IN.kind == TOK_IN) begin
              ANSWER_OUT.handshake <= (!ctrl_tx_enable || CTRL_TX_DONE_FLAG_IN) ?
                                      HS_NAK : HS_ACK;
              ANSWER_OUT.data_one   <= ctrl_tx_toggle;
              ANSWER_OUT.byte_count <= ctrl_tx_byte_count;
            end else begin
              ANSWER_OUT.handshake <= (!ctrl_rx_enable || CTRL_RX_DONE_FLAG_IN) ?
                                      HS_NAK : HS_ACK;
            end
          end
          4'h1, 4'h2: begin
            if ((TOKEN_IN.endpoint == 4'h1) ? first_ep_force_stall
                                             : second_ep_force_stall) begin
              ANSWER_OUT.handshake <= HS_STALL;
            end else if (TOKEN_IN.kind != TOK_IN ||
                         !((TOKEN_IN.endpoint == 4'h1) ? first_ep_enable
                                                        : second_ep_enable)) begin
              ANSWER_OUT.valid <= 1'b0;
            end else if (!shared_tx_enable || shared_tx_done_flag ||
                         shared_buffer_select != (TOKEN_IN.endpoint == 4'h2)) begin
              ANSWER_OUT.handshake <= HS_NAK;
            end else begin
              ANSWER_OUT.handshake  <= HS_ACK;
              ANSWER_OUT.data_one   <= shared_tx_toggle;
              ANSWER_OUT.byte_count <= shared_tx_byte_count;
              ANSWER_OUT.use_shared <= 1'b1;
            end
          end
          default: begin
            ANSWER_OUT.valid <= 1'b0;
          end
        endcase
      end
    end
  end

  // AXI read side
  logic [7:0] rd_byte;
  logic [7:0] rd_idx;
  assign rd_idx = word_index(S_AXI_ARADDR_IN);
  always_comb begin
    rd_byte = 8'h00;
    case (rd_idx)
      IDX_EVENT_FLAGS_ONE: rd_byte = {shared_tx_done_flag, end_packet_flag,
                                      wakeup_seen_flag, 1'b0, shared_tx_irq_enable,
                                      end_packet_irq_enable, 2'b00};
      IDX_EP0_CONTROL:     rd_byte = {ctrl_tx_toggle, ctrl_force_stall, ctrl_tx_enable,
                                      ctrl_rx_enable, ctrl_tx_byte_count};
      IDX_EP12_CONTROL:    rd_byte = {shared_tx_toggle, shared_buffer_select,
                                      shared_tx_enable, force_wakeup_drive,
                                      shared_tx_byte_count};
      IDX_EP12_EN_STALL:   rd_byte = {2'b00, in_before_out_flag, 1'b0, second_ep_enable,
                                      first_ep_enable, second_ep_force_stall,
                                      first_ep_force_stall};
      default:             rd_byte = 8'h00;
    endcase
  end

  always_ff @(posedge CLK_IN) begin
    if (SRST_IN) begin
      S_AXI_ARREADY_OUT <= 1'b0;
      S_AXI_RVALID_OUT  <= 1'b0;
      S_AXI_RDATA_OUT   <= '0;
      S_AXI_RRESP_OUT   <= AXI_OKAY;
    end else begin
      S_AXI_ARREADY_OUT <= !S_AXI_RVALID_OUT && !S_AXI_ARREADY_OUT && S_AXI_ARVALID_IN;
      if (S_AXI_ARVALID_IN && S_AXI_ARREADY_OUT) begin
        S_AXI_RVALID_OUT <= 1'b1;
        S_AXI_RDATA_OUT  <= {24'h000000, rd_byte};
        S_AXI_RRESP_OUT  <= ((S_AXI_ARADDR_IN[ADDR_W-1:10] == '0) && idx_mapped(rd_idx)) ?
                            AXI_OKAY : AXI_SLVERR;
      end else if (S_AXI_RREADY_IN) begin
        S_AXI_RVALID_OUT <= 1'b0;
      end
    end
  end

endmodule

// *** tb/usb_hs_chk.sv ***
`timescale 1ns/100ps
module usb_hs_chk
  import usb_hs_pkg::*;
(
  input wire logic        CLK_IN,
  input wire logic        SRST_IN,
  input wire token_s      TOKEN_IN,
  input wire logic        SUSPEND_BIT_IN,
  input wire logic        MODULE_ENABLE_IN,
  input wire answer_s     ANSWER_OUT,
  input wire logic        USB_IRQ_OUT,
  input wire logic        S_AXI_BVALID_OUT,
  input wire logic        S_AXI_BREADY_IN,
  input wire logic        S_AXI_RVALID_OUT,
  input wire logic        S_AXI_RREADY_IN,
  input wire logic [31:0] S_AXI_RDATA_OUT
);
  default clocking @(posedge CLK_IN); endclocking
  default disable iff (SRST_IN);
  property p_ans_cause;
    ANSWER_OUT.valid |-> $past(TOKEN_IN.valid);
  endproperty
  a_ans_cause: assert property (p_ans_cause)
    else $error("answer without a token");
  property p_off_quiet;
    TOKEN_IN.valid && !MODULE_ENABLE_IN |=> !ANSWER_OUT.valid;
  endproperty
  a_off_quiet: assert property (p_off_quiet)
    else $error("answer while module off");
  property p_susp_quiet;
    TOKEN_IN.valid && SUSPEND_BIT_IN |=> !ANSWER_OUT.valid;
  endproperty
  a_susp_quiet: assert property (p_susp_quiet)
    else $error("answer while suspended");
  property p_ep_range;
    TOKEN_IN.valid && TOKEN_IN.endpoint > 4'h2 |=> !ANSWER_OUT.valid;
  endproperty
  a_ep_range: assert property (p_ep_range)
    else $error("answer for unknown endpoint");
  property p_setup_ack;
    TOKEN_IN.valid && TOKEN_IN.kind == TOK_SETUP && TOKEN_IN.endpoint == 4'h0
      && MODULE_ENABLE_IN && !SUSPEND_BIT_IN |=> ANSWER_OUT.valid
      && ANSWER_OUT.handshake == HS_ACK;
  endproperty
  a_setup_ack: assert property (p_setup_ack)
    else $error("setup not acknowledged");
  property p_irq_pulse;
    USB_IRQ_OUT |=> !USB_IRQ_OUT;
  endproperty
  a_irq_pulse: assert property (p_irq_pulse)
    else $error("interrupt longer than a pulse");
  property p_b_hold;
    S_AXI_BVALID_OUT && !S_AXI_BREADY_IN |=> S_AXI_BVALID_OUT;
  endproperty
  a_b_hold: assert property (p_b_hold)
    else $error("write response dropped");
  property p_r_hold;
    S_AXI_RVALID_OUT && !S_AXI_RREADY_IN |=> S_AXI_RVALID_OUT && $stable(S_AXI_RDATA_OUT);
  endproperty
  a_r_hold: assert property (p_r_hold)
    else $error("read data not held");
  property p_hi_zero;
    S_AXI_RVALID_OUT |-> S_AXI_RDATA_OUT[31:8] == 24'h0;
  endproperty
  a_hi_zero: assert property (p_hi_zero)
    else $error("upper read bits not zero");
endmodule
bind usb_endpoint_handshake_control usb_hs_chk chk (.*);

// *** tb/usb_host_model.sv ***
`timescale 1ns/100ps
module usb_host_model
  import usb_hs_pkg::*;
(
  input  wire logic clk,
  output token_s    token,
  output logic      acked,
  output logic      dp,
  output logic      dm
);
  // Idle bus is low-speed J, D- high
  initial begin
    token = '0;
    acked = 1'b0;
    dp = 1'b0;
    dm = 1'b1;
  end
  task automatic send(input token_e k, input logic [3:0] ep);
    @(posedge clk);
    token <= '{valid: 1'b1, kind: k, endpoint: ep};
    @(posedge clk);
    token <= '0;
  endtask
  task automatic ack();
    @(posedge clk);
    acked <= 1'b1;
    @(posedge clk);
    acked <= 1'b0;
  endtask
  task automatic lines(input logic p, input logic m, input int n);
    @(posedge clk);
    dp <= p;
    dm <= m;
    repeat (n) @(posedge clk);
  endtask
endmodule

// *** tb/usb_endpoint_handshake_control_tb.sv ***
`timescale 1ns/100ps
module usb_endpoint_handshake_control_tb;
  import usb_hs_pkg::*;
  logic              clk = 1'b0, rst = 1'b1;
  logic [ADDR_W-1:0] awaddr = '0, araddr = '0;
  logic [31:0]       wdata = '0, rdata;
  logic              awv = 0, wv = 0, bready = 0, arv = 0, rready = 0;
  logic              awr, wrdy, bv, arr, rv, drive_k, irq, dp_h, dm_h, acked;
  logic              txf = 0, rxf = 0, rxs = 0, susp = 0, men = 1;
  logic [1:0]        bresp, rresp, resp;
  token_s            tok_w;
  answer_s           ans;
  int                num_errors = 0, num_checks = 0;
  initial forever #5 clk = ~clk;
  usb_host_model host (.clk(clk), .token(tok_w), .acked(acked), .dp(dp_h), .dm(dm_h));
  // Forced K from the device wins on the wire
  usb_endpoint_handshake_control dut (
    .CLK_IN(clk), .SRST_IN(rst), .S_AXI_AWADDR_IN(awaddr), .S_AXI_AWVALID_IN(awv),
    .S_AXI_AWREADY_OUT(awr), .S_AXI_WDATA_IN(wdata), .S_AXI_WSTRB_IN(4'hf),
    .S_AXI_WVALID_IN(wv), .S_AXI_WREADY_OUT(wrdy), .S_AXI_BRESP_OUT(bresp),
    .S_AXI_BVALID_OUT(bv), .S_AXI_BREADY_IN(bready), .S_AXI_ARADDR_IN(araddr),
    .S_AXI_ARVALID_IN(arv), .S_AXI_ARREADY_OUT(arr), .S_AXI_RDATA_OUT(rdata),
    .S_AXI_RRESP_OUT(rresp), .S_AXI_RVALID_OUT(rv), .S_AXI_RREADY_IN(rready),
    .TOKEN_IN(tok_w), .SHARED_TX_ACKED_IN(acked), .CTRL_RX_SETTING_IN(rxs),
    .CTRL_TX_DONE_FLAG_IN(txf), .CTRL_RX_DONE_FLAG_IN(rxf), .SUSPEND_BIT_IN(susp),
    .MODULE_ENABLE_IN(men), .LINE_DP_IN(drive_k | dp_h), .LINE_DM_IN(dm_h & ~drive_k),
    .ANSWER_OUT(ans), .DRIVE_K_OUT(drive_k), .USB_IRQ_OUT(irq));
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic hang(input int n);
    if (n >= 40) begin
      num_errors++;
      tally_and_finish();
    end
  endtask
  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    int n;
    @(posedge clk);
    awaddr <= {2'b00, idx, 2'b00};
    wdata <= {24'h0, d};
    awv <= 1'b1;
    wv <= 1'b1;
    // Response waits a cycle before bready, so its hold is exercised
    for (n = 0; n < 40; n++) begin
      @(posedge clk);
      if (awr) awv <= 1'b0;
      if (wrdy) wv <= 1'b0;
      if (bv && bready) break;
      if (bv) bready <= 1'b1;
    end
    bready <= 1'b0;
    resp = bresp;
    hang(n);
  endtask
  task automatic rd(input logic [7:0] idx, input logic [7:0] exp);
    int n;
    @(posedge clk);
    araddr <= {2'b00, idx, 2'b00};
    arv <= 1'b1;
    for (n = 0; n < 40; n++) begin
      @(posedge clk);
      if (arr) arv <= 1'b0;
      if (rv && rready) break;
      if (rv) rready <= 1'b1;
    end
    rready <= 1'b0;
    resp = rresp;
    hang(n);
    chk(rdata, {24'h0, exp});
  endtask
  task automatic tok(input token_e k, input logic [3:0] ep, input logic [8:0] e, m);
    host.send(k, ep);
    #1;
    chk({23'h0, ans & m}, {23'h0, e & m});
  endtask
  // Pulse may already be up on entry, so look before waiting
  task automatic irq_wait();
    int n;
    for (n = 0; n < 8; n++) begin
      #1;
      if (irq === 1'b1) break;
      @(posedge clk);
    end
    chk({31'h0, irq}, 32'h1);
  endtask
  function automatic logic [1:0] want(input logic st, input logic ok);
    return st ? HS_STALL : (ok ? HS_ACK : HS_NAK);
  endfunction
  initial begin
    logic [1:0] hs;
    logic [3:0] c;
    void'($urandom(54716));
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    rd(IDX_EVENT_FLAGS_ONE, RESET_BYTE);
    rd(IDX_EP0_CONTROL, RESET_BYTE);
    rd(IDX_EP12_CONTROL, RESET_BYTE);
    rd(IDX_EP12_EN_STALL, RESET_BYTE);
    rd(8'h01, 8'h00);
    chk({30'h0, resp}, {30'h0, AXI_SLVERR});
    $display("test reset done");
    for (int i = 0; i < 16; i++) begin
      c = 4'($urandom);
      wr(IDX_EP0_CONTROL, {i[3], i[0], i[1], i[1], c});
      txf <= i[2];
      rxf <= i[2];
      hs = want(i[0], i[1] & !i[2]);
      tok(TOK_IN, 4'h0, {1'b1, hs, i[3], c, 1'b0}, hs == HS_ACK ? 9'h1ff : 9'h1c0);
      tok(TOK_OUT, 4'h0, {1'b1, hs, 6'h0}, 9'h1c0);
      rd(IDX_EP0_CONTROL, {i[3], i[0], i[1], i[1], c});
    end
    rxs <= 1'b1;
    @(posedge clk);
    rxs <= 1'b0;
    rd(IDX_EP12_EN_STALL, 8'h20);
    wr(IDX_EP12_EN_STALL, 8'h40);
    txf <= 1'b0;
    rxf <= 1'b0;
    rd(IDX_EP12_EN_STALL, 8'h00);
    wr(IDX_EP0_CONTROL, 8'h40);
    tok(TOK_SETUP, 4'h0, {1'b1, HS_ACK, 6'h0}, 9'h1c0);
    rd(IDX_EP0_CONTROL, 8'h00);
    $display("test endpoint0 done");
    c = 4'($urandom);
    wr(IDX_EP12_EN_STALL, 8'h0c);
    wr(IDX_EVENT_FLAGS_ONE, 8'h0c);
    wr(IDX_EP12_CONTROL, {4'ha, c});
    tok(TOK_IN, 4'h2, {1'b1, HS_NAK, 6'h0}, 9'h1c0);
    tok(TOK_IN, 4'h1, {1'b1, HS_ACK, 1'b1, c, 1'b1}, 9'h1ff);
    host.ack();
    irq_wait();
    rd(IDX_EVENT_FLAGS_ONE, 8'h8c);
    tok(TOK_IN, 4'h1, {1'b1, HS_NAK, 6'h0}, 9'h1c0);
    wr(IDX_EVENT_FLAGS_ONE, 8'h0c);
    rd(IDX_EVENT_FLAGS_ONE, 8'h8c);
    wr(IDX_EVENT_FLAGS_ONE, 8'h0e);
    rd(IDX_EVENT_FLAGS_ONE, 8'h0c);
    wr(IDX_EP12_CONTROL, 8'h00);
    wr(IDX_EP12_EN_STALL, 8'h0d);
    tok(TOK_IN, 4'h1, {1'b1, HS_STALL, 6'h0}, 9'h1c0);
    tok(TOK_OUT, 4'h1, {1'b1, HS_STALL, 6'h0}, 9'h1c0);
    wr(IDX_EP12_EN_STALL, 8'h00);
    tok(TOK_IN, 4'h1, 9'h000, 9'h100);
    men <= 1'b0;
    tok(TOK_IN, 4'h0, 9'h000, 9'h100);
    men <= 1'b1;
    $display("test shared done");
    host.lines(1'b0, 1'b0, 3);
    host.lines(1'b0, 1'b1, 1);
    irq_wait();
    rd(IDX_EVENT_FLAGS_ONE, 8'h4c);
    wr(IDX_EVENT_FLAGS_ONE, 8'h0d);
    rd(IDX_EVENT_FLAGS_ONE, 8'h0c);
    susp <= 1'b1;
    wr(IDX_EP12_CONTROL, 8'h10); // hold shortened, software owns the timing
    #1;
    chk({31'h0, drive_k}, 32'h1);
    wr(IDX_EP12_CONTROL, 8'h00);
    repeat (4) @(posedge clk);
    rd(IDX_EVENT_FLAGS_ONE, 8'h0c);
    host.lines(1'b1, 1'b0, 4);
    host.lines(1'b0, 1'b1, 4);
    rd(IDX_EVENT_FLAGS_ONE, 8'h2c);
    susp <= 1'b0;
    wr(IDX_EVENT_FLAGS_ONE, 8'h1c);
    rd(IDX_EVENT_FLAGS_ONE, 8'h0c);
    $display("test bus events done");
    tally_and_finish();
  end
endmodule
